// ### src/tcm_top.sv
// Purpose: Capture/compare channel configuration and behaviour, two channels
// Assumes: APB slave, zero wait states, counter supplied by the timer core
// Notes:   Compare and capture views share the control word storage
//          Upper half of the pair is reserved and reads zero
//
// Contract
// - Modes 000-100 freeze, set, clear, toggle, force low
// - Mode 101 is PWM mode 0
// - Mode 111 is PWM mode 1
// - PWM level changes on entry from freeze or comparison change
// - Compare control locked at full lock in output
// - Shadow enable locked at full lock in output
// - Shadow compare value loads at update event
// - Fast enable turns trigger edge into match
// - Mode field picks output or capture source
// - Mode field writable only while channel disabled
// - Filter counts consecutive equal samples before accepting
// - Filter code sets sample count and rate
// - Prescaler captures every 1, 2, 4, 8 edges
// - Prescaler counter clears while channel disabled
// - Channel 1 fields sit at bits 15:8
// - Control pair at 0x1C, resets zero, word access
// - External trigger with clear enable drops level
`timescale 1ns/10ps
module tcm_top import tcm_pkg::*; (
	input  wire logic        clk_i,                  // Kernel clock, 250 MHz
	input  wire logic        resetn_i,               // Async reset, active low
	input  wire logic [7:0]  paddr_i,                // APB address
	input  wire logic        psel_i,                 // APB select
	input  wire logic        penable_i,              // APB access phase
	input  wire logic        pwrite_i,               // APB direction
	input  wire logic [31:0] pwdata_i,               // APB write data
	input  wire logic [3:0]  pstrb_i,                // APB byte strobes
	output logic      [31:0] prdata_o,               // APB read data
	output logic             pready_o,               // APB ready
	output logic             pslverr_o,              // APB error
	input  wire logic [15:0] counter_value_i,        // Timer counter
	input  wire logic        count_down_i,           // Counter direction
	input  wire logic        update_event_i,         // Update event pulse
	input  wire logic        internal_trigger_sel_i, // Internal trigger
	input  wire logic        ext_trigger_filtered_i, // Filtered ext trigger
	input  wire logic [1:0]  ch_input_pin_i,         // Channel input pins
	output logic      [1:0]  ch_output_pin_o,        // Output-prepare levels
	output logic      [1:0]  capture_o               // Capture pulses
);
	// Enables and lock level sit in a local control word
	// Register state
	logic [15:0] chctl_q, chctl_d;      // Shared compare/capture fields
	logic [1:0]  en_q, en_d;            // Channel enables
	logic [1:0]  lock_q, lock_d;        // Lock level
	logic [15:0] cv_sh_q [2];           // Shadow compare values
	logic [15:0] cv_sh_d [2];
	logic [15:0] cv_act_q [2];          // Active compare / captured values
	logic [15:0] cv_act_d [2];
	logic [31:0] prdata_q, prdata_d;    // Registered read data
	// Capture path state
	logic [2:0]  psc_q [2];             // Prescaler edge counters
	logic [2:0]  psc_d [2];
	logic [1:0]  sel_q, sel_d;          // Selected input, last cycle
	logic [1:0]  cap_q, cap_d;          // Capture pulses
	logic        trig_q;                // Trigger, last cycle
	logic [4:0]  dts_q;                 // Dead-time rate divider
	// Decoded views
	logic [1:0]  ms [2];                // Mode select per channel
	logic [1:0]  filt;                  // Filtered pins
	logic [1:0]  opre;                  // Output-prepare levels
	logic [5:0]  rate_en;               // Sample strobes per rate
	logic        wr, rd_setup, mapped;  // Bus decode
	logic        trig_edge;             // Trigger rising edge

	// Bus decode; zero wait states
	assign wr        = psel_i && penable_i && pwrite_i;
	assign rd_setup  = psel_i && !penable_i;
	assign mapped    = paddr_i == ADDR_CTRL || paddr_i == ADDR_CV0 || paddr_i == ADDR_CV1
		|| paddr_i == ADDR_STAT || paddr_i == ADDR_CHCTL;
	// Every access completes in its first access cycle
	assign pready_o  = 1'b1;
	// Unmapped, or partial write to the control pair
	assign pslverr_o = psel_i && penable_i && (!mapped
		|| (pwrite_i && paddr_i == ADDR_CHCTL && pstrb_i != 4'hf));
	assign prdata_o  = prdata_q;
	// History resets low, the trigger's idle level
	assign trig_edge = internal_trigger_sel_i && !trig_q;
	assign ch_output_pin_o = opre;
	// Registered, one cycle after the edge
	assign capture_o = cap_q;

	// Dead-time rate strobes, one-cycle pulses
	// Rate k fires once every 2^k cycles
	always_comb begin
		rate_en[0] = 1'b1;
		for (int k = 1; k < 6; k++) begin
			rate_en[k] = (dts_q & 5'((6'h1 << k) - 6'h1)) == 5'((6'h1 << k) - 6'h1);
		end
	end

	// Per-channel input filter and compare output
	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign ms[c] = chctl_q[c*CH_STRIDE +: 2];
		// Filter code overlays compare control and clear enable
		tcm_in_filt i_tcm_in_filt (
			.clk_i    (clk_i),
			.resetn_i (resetn_i),
			.pin_i    (ch_input_pin_i[c]),
			.code_i   (chctl_q[c*CH_STRIDE+4 +: 4]), // Capture view
			.rate_en_i(rate_en),
			.filt_o   (filt[c])
		);
		// Compare fields, used only while in output mode
		tcm_oc_chan i_tcm_oc_chan (
			.clk_i      (clk_i),
			.resetn_i   (resetn_i),
			.active_i   (ms[c] == MS_OUTPUT), // Compare view
			.mode_i     (tcm_oc_mode_t'(chctl_q[c*CH_STRIDE+4 +: 3])),
			.fast_en_i  (chctl_q[c*CH_STRIDE+2]),
			.clear_en_i (chctl_q[c*CH_STRIDE+7]),
			.ext_trig_i (ext_trigger_filtered_i),
			.trig_edge_i(trig_edge),
			.down_i     (count_down_i),
			.cnt_i      (counter_value_i),
			.cv_i       (cv_act_q[c]),
			.opre_o     (opre[c])
		);
	end

	// Input source selection and capture prescaler
	// Mode 10 reads the neighbour's filtered input
	always_comb begin
		logic       src;
		logic [1:0] pv;
		src = 1'b0;
		pv  = 2'h0;
		cap_d = 2'h0;
		for (int c = 0; c < 2; c++) begin
			pv = chctl_q[c*CH_STRIDE+2 +: 2];
			unique case (ms[c])
				MS_OWN:   src = filt[c];
				MS_NEIGH: src = filt[c ^ 1];
				MS_TRIG:  src = internal_trigger_sel_i;
				default:  src = 1'b0;               // Output mode
			endcase
			// Source history for rising-edge detection
			sel_d[c] = src;
			psc_d[c] = psc_q[c];
			if (!en_q[c] || ms[c] == MS_OUTPUT) begin
				psc_d[c] = 3'h0;
			end else if (src && !sel_q[c]) begin
				// Rising edge; capture on the last edge of the group
				// A count left over from a larger ratio fires at once
				if (psc_q[c] >= 3'((4'h1 << pv) - 4'h1)) begin
					cap_d[c] = 1'b1;
					psc_d[c] = 3'h0;
				end else begin
					psc_d[c] = psc_q[c] + 3'h1;
				end
			end
		end
	end

	// Register writes, shadow loading and capture
	always_comb begin
		logic [7:0]  b;
		logic [7:0]  w;
		logic        wcv;
		b = 8'h00;
		w = 8'h00;
		wcv = 1'b0;
		en_d = en_q;
		lock_d = lock_q;
		chctl_d = chctl_q;
		cv_sh_d = cv_sh_q;
		cv_act_d = cv_act_q;
		// Control word: channel enables and lock level
		if (wr && paddr_i == ADDR_CTRL) begin
			en_d = pwdata_i[CTRL_EN +: 2];
			lock_d = pwdata_i[CTRL_LOCK +: 2];
		end
		for (int c = 0; c < 2; c++) begin
			// One byte per channel in the pair
			b = chctl_q[c*CH_STRIDE +: 8];
			w = pwdata_i[c*CH_STRIDE +: 8];
			if (wr && paddr_i == ADDR_CHCTL && pstrb_i == 4'hf) begin
				if (!en_q[c]) begin
					b[1:0] = w[1:0];
				end
				// Fast and clear enables are never locked
				b[2] = w[2];
				b[7] = w[7];
				if (!(lock_q == LOCK_FULL && ms[c] == MS_OUTPUT)) begin
					b[6:3] = w[6:3];
				end
			end
			chctl_d[c*CH_STRIDE +: 8] = b;
			// Compare writes count only in output mode
			wcv = wr && paddr_i == (c == 0 ? ADDR_CV0 : ADDR_CV1) && ms[c] == MS_OUTPUT;
			if (wcv) begin
				cv_sh_d[c] = pwdata_i[15:0];
				if (!chctl_q[c*CH_STRIDE+3]) begin
					cv_act_d[c] = pwdata_i[15:0]; // Shadow bypassed
				end
			end
			// Update event copies shadow to active
			if (update_event_i && chctl_q[c*CH_STRIDE+3] && ms[c] == MS_OUTPUT) begin
				cv_act_d[c] = cv_sh_q[c];
			end
			// Capture wins over write and update
			if (cap_d[c]) begin
				cv_act_d[c] = counter_value_i; // Capture into same storage
			end
		end
	end

	// Read data, captured in the setup phase
	always_comb begin
		prdata_d = prdata_q;
		// Sampled in setup, so access sees a steady word
		if (rd_setup) begin
			unique case (paddr_i)
				ADDR_CTRL:  prdata_d = {28'h0, lock_q, en_q};
				ADDR_CV0:   prdata_d = {16'h0, cv_act_q[0]};
				ADDR_CV1:   prdata_d = {16'h0, cv_act_q[1]};
				ADDR_STAT:  prdata_d = {28'h0, filt, opre};
				ADDR_CHCTL: prdata_d = {16'h0, chctl_q}; // Upper half reserved
				default:    prdata_d = 32'h0;
			endcase
		end
	end

	// All registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chctl_q  <= CHCTL_RST;
			en_q     <= EN_RST;
			lock_q   <= LOCK_RST;
			cv_sh_q  <= '{CV_RST, CV_RST};
			cv_act_q <= '{CV_RST, CV_RST};
			prdata_q <= 32'h0;
			psc_q    <= '{3'h0, 3'h0};
			sel_q    <= 2'h0;
			cap_q    <= 2'h0;
			trig_q   <= 1'b0;
			dts_q    <= 5'h0;
		end else begin
			chctl_q  <= chctl_d;
			en_q     <= en_d;
			lock_q   <= lock_d;
			cv_sh_q  <= cv_sh_d;
			cv_act_q <= cv_act_d;
			prdata_q <= prdata_d;
			psc_q    <= psc_d;
			sel_q    <= sel_d;
			cap_q    <= cap_d;
			// Trigger history for edge detection
			trig_q   <= internal_trigger_sel_i;
			// Free-running, wraps every 32 cycles
			dts_q    <= dts_q + 5'h1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	AST_LOCK_COMCTL: assert property (
		(wr && paddr_i == ADDR_CHCTL && lock_q == LOCK_FULL && ms[0] == MS_OUTPUT)
		|=> $stable(chctl_q[6:4]))
		else $error("Locked compare control changed");
	AST_LOCK_SHADOW: assert property (
		(wr && paddr_i == ADDR_CHCTL && lock_q == LOCK_FULL && ms[0] == MS_OUTPUT)
		|=> $stable(chctl_q[3]))
		else $error("Locked shadow enable changed");
	AST_MS_ENABLED: assert property (
		(wr && paddr_i == ADDR_CHCTL && en_q[0]) |=> $stable(chctl_q[1:0]))
		else $error("Mode field written while enabled");
	AST_SHADOW_HOLD: assert property (
		(wr && paddr_i == ADDR_CV0 && chctl_q[3] && !update_event_i && !cap_d[0])
		|=> $stable(cv_act_q[0]))
		else $error("Shadowed compare value took effect early");
	AST_PSC_CLEAR: assert property (
		!en_q[1] |=> psc_q[1] == 3'h0)
		else $error("Prescaler not cleared while disabled");
	// Capture checks watch channel 1, the one the scenarios drive
	AST_PSC_EVERY: assert property (
		(en_q[1] && ms[1] != MS_OUTPUT && chctl_q[11:10] == 2'h0 && sel_d[1] && !sel_q[1])
		|=> capture_o[1])
		else $error("Undivided edge gave no capture");
	AST_CHCTL_UPPER: assert property (
		(rd_setup && paddr_i == ADDR_CHCTL) |=> prdata_o == {16'h0, $past(chctl_q)})
		else $error("Control pair read back wrong");
	AST_CAP_STORE: assert property (
		cap_d[1] |=> cv_act_q[1] == $past(counter_value_i))
		else $error("Capture did not store the counter");
	AST_CV_BYPASS: assert property (
		(wr && paddr_i == ADDR_CV0 && ms[0] == MS_OUTPUT && !chctl_q[3])
		|=> cv_act_q[0] == $past(pwdata_i[15:0]))
		else $error("Unshadowed compare value not taken");
	CV_CAPTURE8: cover property (capture_o[1] && chctl_q[11:10] == 2'h3);
	CV_LOCKED_WR: cover property (wr && paddr_i == ADDR_CHCTL && lock_q == LOCK_FULL);
	CV_SHADOW_LOAD: cover property (update_event_i && chctl_q[3] && ms[0] == MS_OUTPUT);
endmodule

// ### src/tcm_pkg.sv
// Purpose: Shared constants and types for the timer channel mode block
// Assumes: 32-bit APB register access, one 250 MHz kernel clock
// Notes:   Dead-time sample clock equals the kernel clock here
package tcm_pkg;
	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL  = 8'h00; // Enables and lock level
	localparam logic [7:0]  ADDR_CV0   = 8'h04; // Channel 0 compare value
	localparam logic [7:0]  ADDR_CV1   = 8'h08; // Channel 1 compare value
	localparam logic [7:0]  ADDR_STAT  = 8'h0c; // Live channel state
	localparam logic [7:0]  ADDR_CHCTL = 8'h1c; // Channel control upper pair
	// Reset values
	localparam logic [15:0] CHCTL_RST  = 16'h0000;
	localparam logic [15:0] CV_RST     = 16'h0000;
	localparam logic [1:0]  EN_RST     = 2'h0;
	localparam logic [1:0]  LOCK_RST   = 2'h0;
	// Field positions
	localparam int CH_STRIDE = 8;  // Bits per channel in control word
	localparam int CTRL_EN   = 0;  // Enable field lsb in control reg
	localparam int CTRL_LOCK = 2;  // Lock field lsb in control reg
	localparam int STAT_FILT = 2;  // Filtered input field in status
	// Mode select codes
	localparam logic [1:0]  MS_OUTPUT  = 2'h0;
	localparam logic [1:0]  MS_OWN     = 2'h1;
	localparam logic [1:0]  MS_NEIGH   = 2'h2;
	localparam logic [1:0]  MS_TRIG    = 2'h3;
	localparam logic [1:0]  LOCK_FULL  = 2'h3;
	// Compare output control encodings, in code order
	typedef enum logic [2:0] {
		OC_TIMING, OC_SET, OC_CLR, OC_TOGGLE, OC_LOW, OC_PWM0, OC_HIGH, OC_PWM1
	} tcm_oc_mode_t;
	// Filter: samples needed and sample rate (0 kernel, k = dead-time / 2^k)
	localparam logic [3:0] FLT_NEED [16] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6,
		4'h8, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};
	localparam logic [2:0] FLT_RATE [16] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2,
		3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
endpackage

// ### src/tcm_in_filt.sv
// Purpose: Pin synchroniser and digital input filter for one channel
// Assumes: Sample enables are one-cycle pulses on the kernel clock
// Notes:   Filter code zero passes the synchronised level straight on
`timescale 1ns/10ps
module tcm_in_filt import tcm_pkg::*; (
	input  wire logic       clk_i,     // Kernel clock
	input  wire logic       resetn_i,  // Async reset, active low
	input  wire logic       pin_i,     // Raw channel pin
	input  wire logic [3:0] code_i,    // Filter code
	input  wire logic [5:0] rate_en_i, // Sample enables per rate
	output logic            filt_o     // Filtered level
);
	logic       s1_q, s2_q, s3_q; // Three-stage synchroniser
	logic       in_q, in_d;       // Agreed input level
	logic       out_q, out_d;     // Accepted level
	logic [3:0] cnt_q, cnt_d;     // Consecutive new-level samples
	logic       smp_en;           // Sample strobe for this code

	assign smp_en = rate_en_i[FLT_RATE[code_i]];
	assign filt_o = out_q;

	// Next level and sample count
	always_comb begin
		in_d  = (s2_q == s3_q) ? s3_q : in_q; // Stage 1 never looked at
		out_d = out_q;
		cnt_d = cnt_q;
		if (code_i == 4'h0) begin
			// Unfiltered
			out_d = in_q;
			cnt_d = 4'h0;
		end else if (smp_en) begin
			if (in_q != out_q) begin
				// Count identical samples of the new level
				if (cnt_q + 4'h1 >= FLT_NEED[code_i]) begin
					out_d = in_q;
					cnt_d = 4'h0;
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end else begin
				// Glitch broke the run
				cnt_d = 4'h0;
			end
		end
	end

	// State registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			in_q  <= 1'b0;
			out_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			s1_q  <= pin_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			in_q  <= in_d;
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	AST_FILT_ON_SAMPLE: assert property (
		(code_i != 4'h0 && $stable(code_i) && out_d != out_q) |-> smp_en)
		else $error("Filtered level moved off a sample strobe");
endmodule

// ### src/tcm_oc_chan.sv
// Purpose: Output-prepare level generation for one compare channel
// Assumes: Counter and direction come from the kernel clock domain
// Notes:   Clear from external trigger overrides every mode
`timescale 1ns/10ps
module tcm_oc_chan import tcm_pkg::*; (
	input  wire logic         clk_i,      // Kernel clock
	input  wire logic         resetn_i,   // Async reset, active low
	input  wire logic         active_i,   // Channel in output mode
	input  wire tcm_oc_mode_t mode_i,     // Compare output control
	input  wire logic         fast_en_i,  // Fast trigger response
	input  wire logic         clear_en_i, // Clear on external trigger
	input  wire logic         ext_trig_i, // Filtered external trigger
	input  wire logic         trig_edge_i,// Trigger rising edge
	input  wire logic         down_i,     // Counting down
	input  wire logic [15:0]  cnt_i,      // Counter value
	input  wire logic [15:0]  cv_i,       // Active compare value
	output logic              opre_o      // Output-prepare level
);
	logic         opre_q, opre_d; // Output-prepare level
	logic         cmp_q;          // Comparison seen last cycle
	tcm_oc_mode_t mode_q;         // Mode seen last cycle
	logic         cmp, match, pwm, pwm0_lvl, upd;

	assign match    = (cnt_i == cv_i);
	// Result kept as the mode 0 level, so a direction flip that moves it counts
	assign cmp      = down_i ? (cnt_i <= cv_i) : (cnt_i < cv_i);
	assign pwm0_lvl = cmp;
	assign pwm      = (mode_i == OC_PWM0) || (mode_i == OC_PWM1);
	// PWM level follows the comparison only on entry from timing or a new comparison
	assign upd      = (mode_q == OC_TIMING) || (cmp != cmp_q);
	assign opre_o   = opre_q;

	// Next output-prepare level
	always_comb begin
		opre_d = opre_q;
		if (active_i && clear_en_i && ext_trig_i) begin
			opre_d = 1'b0;
		end else if (active_i) begin
			unique case (mode_i)
				OC_TIMING: opre_d = opre_q;
				OC_SET:    opre_d = match ? 1'b1 : opre_q;
				OC_CLR:    opre_d = match ? 1'b0 : opre_q;
				OC_TOGGLE: opre_d = match ? !opre_q : opre_q;
				OC_LOW:    opre_d = 1'b0;
				OC_HIGH:   opre_d = 1'b1;
				OC_PWM0: begin
					if (fast_en_i && trig_edge_i) begin
						opre_d = 1'b0; // Match level of mode 0
					end else if (upd) begin
						opre_d = pwm0_lvl;
					end
				end
				OC_PWM1: begin
					if (fast_en_i && trig_edge_i) begin
						opre_d = 1'b1; // Match level of mode 1
					end else if (upd) begin
						opre_d = !pwm0_lvl;
					end
				end
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			opre_q <= 1'b0;
			cmp_q  <= 1'b0;
			mode_q <= OC_TIMING;
		end else begin
			opre_q <= opre_d;
			cmp_q  <= cmp;
			mode_q <= mode_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	AST_CLEAR_EXT: assert property (
		(active_i && clear_en_i && ext_trig_i) |=> !opre_o)
		else $error("External clear did not drop the level");
	AST_FORCE_LOW: assert property (
		(active_i && mode_i == OC_LOW) |=> !opre_o)
		else $error("Force low mode left the level high");
	AST_PWM1_LEVEL: assert property (
		(active_i && mode_i == OC_PWM1 && !(clear_en_i && ext_trig_i)
		&& !(fast_en_i && trig_edge_i) && cmp != cmp_q) |=> (opre_o == !$past(pwm0_lvl)))
		else $error("Mode 1 level wrong after comparison change");
	AST_PWM_HOLD: assert property (
		(active_i && pwm && !upd && !trig_edge_i && !(clear_en_i && ext_trig_i))
		|=> $stable(opre_o))
		else $error("PWM level moved without cause");
	CV_PWM1: cover property (active_i && mode_i == OC_PWM1 && cmp != cmp_q);
	CV_FAST: cover property (active_i && pwm && fast_en_i && trig_edge_i);
endmodule

// ### bench/tcm_pin_model.sv
// Purpose: Far-side model that drives the raw channel input pins
// Assumes: Each level is held longer than the pin synchroniser delay
// Notes:   Pins rest low between bursts, as a quiet sensor line would
`timescale 1ns/10ps
module tcm_pin_model #(
	parameter int HALF = 12 // Level lasts HALF+1 cycles, well above sync latency
) (
	input  wire logic       clk_i,    // Kernel clock
	input  wire logic       resetn_i, // Async reset, active low
	input  wire logic       go_i,     // Start a burst
	input  wire logic [3:0] edges_i,  // Rising edges in the burst
	input  wire logic       sel_i,    // Which pin pulses
	output logic            busy_o,   // Burst in progress
	output logic      [1:0] pin_o     // Raw pin levels
);
	logic [4:0] left_q; // Level changes still to emit
	logic [4:0] tick_q; // Cycles left at this level
	assign busy_o = (left_q != 5'h00);
	// Every rising edge comes with its falling edge, so a burst ends low
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			left_q <= 5'h00;
			tick_q <= 5'h00;
			pin_o  <= 2'h0;
		end else if (go_i && !busy_o) begin
			left_q <= {edges_i, 1'b0};
			tick_q <= 5'(HALF);
		end else if (busy_o) begin
			if (tick_q == 5'h00) begin
				pin_o[sel_i] <= ~pin_o[sel_i];
				left_q       <= left_q - 5'h01;
				tick_q       <= 5'(HALF);
			end else begin
				tick_q <= tick_q - 5'h01;
			end
		end
	end
endmodule

// ### bench/tb_tcm_top.sv
// Purpose: Self-checking bench for the timer channel mode block
// Assumes: Zero-wait APB slave, output level registered one cycle
// Notes:   Channel 0 checks compare modes, channel 1 checks capture
`timescale 1ns/10ps
module tb_tcm_top import tcm_pkg::*;;
	logic        clk_i = 0;       // Kernel clock
	logic        resetn_i = 0;    // Reset, active low
	logic [7:0]  paddr = 8'h00;   // APB address
	logic        psel = 0;        // APB select
	logic        penable = 0;     // APB access phase
	logic        pwrite = 0;      // APB direction
	logic [31:0] pwdata = 0;      // APB write data
	logic [3:0]  pstrb = 4'hf;    // APB strobes
	logic [31:0] prdata;          // APB read data
	logic        pready;          // APB ready
	logic        pslverr;         // APB error
	logic [15:0] cnt = 16'h0005;  // Counter value
	logic        down = 0;        // Counting down
	logic        upd = 0;         // Update event
	logic        trig = 0;        // Internal trigger
	logic        etrig = 0;       // External trigger
	logic        go = 0;          // Burst request
	logic [3:0]  edges = 4'h8;    // Edges per burst
	logic        busy;            // Burst running
	logic [1:0]  pins;            // Raw pins
	logic [1:0]  outp;            // Output-prepare levels
	logic [1:0]  cap;             // Capture pulses
	int          miscompares = 0; // Mismatches
	int          n_checks = 0;    // Comparisons
	int          capcnt = 0;      // Channel 1 captures seen
	always #2 clk_i = ~clk_i;
	// Count capture pulses of channel 1
	always @(posedge clk_i) if (cap[1] === 1'b1) capcnt++;
	tcm_top i_tcm_top (.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .counter_value_i(cnt),
		.count_down_i(down), .update_event_i(upd), .internal_trigger_sel_i(trig),
		.ext_trigger_filtered_i(etrig), .ch_input_pin_i(pins), .ch_output_pin_o(outp),
		.capture_o(cap));
	tcm_pin_model i_tcm_pin_model (.clk_i(clk_i), .resetn_i(resetn_i), .go_i(go),
		.edges_i(edges), .sel_i(1'b1), .busy_o(busy), .pin_o(pins));
	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; entered right after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= st;
		@(posedge clk_i);
		penable <= 1'b1;
		// No wait count assumed; the bound only stops a hang
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) miscompares++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, 4'hf, r, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, 4'hf, r, e);
		chk(r, exp);
	endtask
	// Hold a counter value, let the registered level settle, check it
	task automatic lvl(input logic [15:0] c, input logic e);
		cnt <= c;
		repeat (3) @(posedge clk_i);
		chk({31'h0, outp[0]}, {31'h0, e});
	endtask
	// One-cycle match with compare value 100
	task automatic hit(input logic e);
		cnt <= 16'd100;
		@(posedge clk_i);
		lvl(16'd5, e);
	endtask
	task automatic t_bus;
		logic [31:0] r;
		logic        e;
		rdc(ADDR_CHCTL, 32'h0);
		apb(1'b0, 8'h40, 32'h0, 4'hf, r, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, ADDR_CHCTL, 32'h10, 4'h3, r, e);
		chk({31'h0, e}, 32'h1);
		rdc(ADDR_CHCTL, 32'h0);
		wr(ADDR_CHCTL, 32'hffff_ffff);
		rdc(ADDR_CHCTL, 32'h0000_ffff);
		wr(ADDR_CHCTL, 32'h0);
		$display("test bus done");
	endtask
	task automatic t_modes;
		wr(ADDR_CV0, 32'd100);
		rdc(ADDR_CV0, 32'd100);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CHCTL, 32'h10);
		hit(1'b1);
		wr(ADDR_CHCTL, 32'h20);
		hit(1'b0);
		wr(ADDR_CHCTL, 32'h30);
		hit(1'b1);
		hit(1'b0);
		wr(ADDR_CHCTL, 32'h10);
		hit(1'b1);
		wr(ADDR_CHCTL, 32'h00);
		hit(1'b1);
		wr(ADDR_CHCTL, 32'h40);
		lvl(16'd5, 1'b0);
		$display("test modes done");
	endtask
	task automatic t_pwm;
		// Shadow on in the same write as PWM, as single pulse mode is not in use
		wr(ADDR_CHCTL, 32'h00);
		wr(ADDR_CHCTL, 32'h78);
		lvl(16'd50, 1'b0);
		lvl(16'd150, 1'b1);
		down <= 1'b1;
		lvl(16'd150, 1'b1);
		lvl(16'd50, 1'b0);
		wr(ADDR_CHCTL, 32'h00);
		wr(ADDR_CHCTL, 32'h58);
		lvl(16'd150, 1'b0);
		lvl(16'd50, 1'b1);
		down <= 1'b0;
		lvl(16'd150, 1'b0);
		lvl(16'd50, 1'b1);
		// PWM to PWM switch with no compare change keeps the level
		wr(ADDR_CHCTL, 32'h78);
		lvl(16'd50, 1'b1);
		lvl(16'd150, 1'b1);
		lvl(16'd50, 1'b0);
		wr(ADDR_CHCTL, 32'h00);
		wr(ADDR_CHCTL, 32'hd8);
		lvl(16'd50, 1'b1);
		etrig <= 1'b1;
		lvl(16'd50, 1'b0);
		etrig <= 1'b0;
		wr(ADDR_CHCTL, 32'h00);
		wr(ADDR_CHCTL, 32'h7c);
		lvl(16'd50, 1'b0);
		trig <= 1'b1;
		lvl(16'd50, 1'b1);
		trig <= 1'b0;
		rdc(ADDR_STAT, 32'h1);
		$display("test pwm done");
	endtask
	task automatic t_shadow;
		wr(ADDR_CHCTL, 32'h78);
		wr(ADDR_CV0, 32'd200);
		rdc(ADDR_CV0, 32'd100);
		upd <= 1'b1;
		@(posedge clk_i);
		upd <= 1'b0;
		rdc(ADDR_CV0, 32'd200);
		wr(ADDR_CHCTL, 32'h70);
		wr(ADDR_CV0, 32'd100);
		rdc(ADDR_CV0, 32'd100);
		$display("test shadow done");
	endtask
	// Burst of edges on pin 1, then wait for the last capture to land
	task automatic burst(input logic [3:0] n);
		int k;
		k = 0;
		edges <= n;
		go    <= 1'b1;
		@(posedge clk_i);
		go    <= 1'b0;
		repeat (2) @(posedge clk_i);
		while (busy === 1'b1 && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 2000) miscompares++;
		repeat (12) @(posedge clk_i);
	endtask
	// Disable channel 1, load the pair, re-enable, clear the count
	task automatic cfg(input logic [31:0] v);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CHCTL, v);
		wr(ADDR_CTRL, 32'h3);
		capcnt = 0;
	endtask
	task automatic t_capture;
		for (int p = 0; p < 4; p++) begin
			cfg(32'h170 | (p << 10));
			burst(4'h8);
			chk(capcnt, 8 >> p);
		end
		// Half a count, then disable: the next half must not complete it
		cfg(32'hd70);
		burst(4'h4);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CTRL, 32'h3);
		burst(4'h4);
		chk(capcnt, 0);
		wr(ADDR_CHCTL, 32'he70);
		rdc(ADDR_CHCTL, 32'hd70);
		// Mode 10 follows the quiet neighbour pin
		cfg(32'h270);
		burst(4'h2);
		chk(capcnt, 0);
		// Mode 11: trigger source is chosen upstream of this block
		cfg(32'h370);
		repeat (3) begin
			trig <= 1'b1;
			@(posedge clk_i);
			trig <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		chk(capcnt, 3);
		// Slow filter rejects short levels, fast one passes them
		cfg(32'hc170);
		burst(4'h2);
		chk(capcnt, 0);
		cfg(32'h3170);
		burst(4'h2);
		chk(capcnt, 2);
		$display("test capture done");
	endtask
	task automatic t_lock;
		wr(ADDR_CTRL, 32'hf);
		wr(ADDR_CHCTL, 32'h548);
		rdc(ADDR_CHCTL, 32'h570);
		$display("test lock done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Run ends well inside 100 us
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		t_bus();
		t_modes();
		t_pwm();
		t_shadow();
		t_capture();
		t_lock();
		give_verdict();
	end
endmodule
